// *** logic/multi_ffc_sequencer.sv ***
// Per-frame correction table sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module multi_ffc_sequencer
   import seq_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              frame_req,
   output var frame_sel_t         frame_sel,
   output logic                   table_clear,
   output logic [TBL_W-1:0]       table_clear_idx
);

   ////////////////////////////////////////////////////////////////////////////////
   // Write channel
   logic              aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
   logic [7:0]        awaddr_q, awaddr_d;
   logic [31:0]       wdata_q, wdata_d;
   logic              do_write;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready  = !w_have_q && !bvalid_q;
   assign do_write      = aw_have_q && w_have_q && !bvalid_q;

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      bvalid_d  = bvalid_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata;
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration state
   logic              seq_on_q, seq_on_d, ffc_en_q, ffc_en_d;
   logic [TBL_W-1:0]  sel_q, sel_d;
   logic [SET_W-1:0]  count_q, count_d, cur_q, cur_d;
   logic [TBL_W-1:0]  map_q [NUM_SETS];
   logic [TBL_W-1:0]  map_d [NUM_SETS];
   logic              rst_pend_q, rst_pend_d, clr_q, clr_d;
   logic              req_q, req_rise, wr_ok, wr_byte0, rst_cmd;
   logic [1:0]        bresp_q, bresp_d;
   frame_sel_t        fsel_q, fsel_d;

   assign req_rise = frame_req && !req_q;
   assign wr_byte0 = s_axi_wstrb[0];

   function automatic logic [SET_W-1:0] next_set(input logic [SET_W-1:0] c,
                                                 input logic [SET_W-1:0] n);
      if (c + 5'h01 >= n)
         return '0;
      return c + 5'h01;
   endfunction : next_set

   always_comb begin
      seq_on_d   = seq_on_q;
      ffc_en_d   = ffc_en_q;
      sel_d      = sel_q;
      count_d    = count_q;
      map_d      = map_q;
      rst_pend_d = rst_pend_q;
      clr_d      = 1'b0;
      cur_d      = cur_q;
      fsel_d     = fsel_q;
      wr_ok      = 1'b1;
      rst_cmd    = 1'b0;
      if (do_write && wr_byte0) begin
         unique case (awaddr_q)
            ADDR_CTRL: begin
               // Bad selector rejects the whole word
               if (wdata_q[CTRL_SEL_LSB +: TBL_W] < TBL_W'(NUM_TABLES)) begin
                  seq_on_d = wdata_q[CTRL_SEQ_ON];
                  ffc_en_d = wdata_q[CTRL_FFC_EN];
                  sel_d    = wdata_q[CTRL_SEL_LSB +: TBL_W];
               end else
                  wr_ok = 1'b0;
            end
            ADDR_COUNT: begin
               if (wdata_q[4:0] >= 5'h01 && wdata_q[4:0] <= SET_W'(NUM_SETS))
                  count_d = wdata_q[4:0];
               else
                  wr_ok = 1'b0;
            end
            ADDR_MAP: begin
               if (wdata_q[MAP_SET_LSB +: SET_W] < SET_W'(NUM_SETS) &&
                   wdata_q[MAP_TBL_LSB +: TBL_W] < TBL_W'(NUM_TABLES))
                  map_d[wdata_q[MAP_SET_LSB +: SET_W]] = wdata_q[MAP_TBL_LSB +: TBL_W];
               else
                  wr_ok = 1'b0;
            end
            ADDR_CMD: begin
               if (wdata_q[CMD_RESET]) begin
                  rst_pend_d = 1'b1;
                  rst_cmd    = 1'b1;
               end
               clr_d = wdata_q[CMD_CLEAR];
            end
            default: wr_ok = 1'b0;
         endcase
      end else if (do_write && !(awaddr_q inside {ADDR_CTRL, ADDR_COUNT, ADDR_MAP, ADDR_CMD})) begin
         wr_ok = 1'b0;
      end
      if (req_rise) begin
         fsel_d.ffc_on = ffc_en_q;
         if (seq_on_q) begin
            // Count lowered below current set restarts at zero
            if (rst_pend_q || cur_q >= count_q)
               cur_d = '0;
            fsel_d.set_idx   = cur_d;
            fsel_d.table_idx = map_q[cur_d];
            cur_d = next_set(cur_d, count_q);
         end else begin
            fsel_d.set_idx   = cur_q;
            fsel_d.table_idx = sel_q;
         end
         // New reset command in the same cycle stays pending
         if (rst_pend_q && !rst_cmd)
            rst_pend_d = 1'b0;
         if (!seq_on_q && rst_pend_q)
            cur_d = '0;
      end
      bresp_d = do_write ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read channel
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;

   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         rdata_d  = '0;
         unique case (s_axi_araddr)
            ADDR_CTRL: begin
               rdata_d[CTRL_SEQ_ON]             = seq_on_q;
               rdata_d[CTRL_FFC_EN]             = ffc_en_q;
               rdata_d[CTRL_SEL_LSB +: TBL_W]   = sel_q;
            end
            ADDR_COUNT:  rdata_d[4:0] = count_q;
            ADDR_MAP:    rdata_d = '0;
            ADDR_CMD:    rdata_d = '0;
            ADDR_STATUS: begin
               rdata_d[ST_SET_LSB +: SET_W] = cur_q;
               rdata_d[ST_TBL_LSB +: TBL_W] = fsel_q.table_idx;
               rdata_d[ST_FFC_BIT]          = fsel_q.ffc_on;
            end
            default:     rresp_d = RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q  <= 1'b0;
         w_have_q   <= 1'b0;
         bvalid_q   <= 1'b0;
         awaddr_q   <= '0;
         wdata_q    <= '0;
         bresp_q    <= RESP_OKAY;
         seq_on_q   <= 1'b0;
         ffc_en_q   <= 1'b0;
         sel_q      <= '0;
         count_q    <= COUNT_RESET;
         cur_q      <= '0;
         rst_pend_q <= 1'b0;
         clr_q      <= 1'b0;
         req_q      <= 1'b0;
         fsel_q     <= '0;
         rvalid_q   <= 1'b0;
         rdata_q    <= '0;
         rresp_q    <= RESP_OKAY;
         for (int i = 0; i < NUM_SETS; i++)
            map_q[i] <= '0;
      end else begin
         aw_have_q  <= aw_have_d;
         w_have_q   <= w_have_d;
         bvalid_q   <= bvalid_d;
         awaddr_q   <= awaddr_d;
         wdata_q    <= wdata_d;
         bresp_q    <= bresp_d;
         seq_on_q   <= seq_on_d;
         ffc_en_q   <= ffc_en_d;
         sel_q      <= sel_d;
         count_q    <= count_d;
         cur_q      <= cur_d;
         rst_pend_q <= rst_pend_d;
         clr_q      <= clr_d;
         req_q      <= frame_req;
         fsel_q     <= fsel_d;
         rvalid_q   <= rvalid_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
         map_q      <= map_d;
      end
   end

   assign s_axi_bvalid    = bvalid_q;
   assign s_axi_bresp     = bresp_q;
   assign s_axi_rvalid    = rvalid_q;
   assign s_axi_rdata     = rdata_q;
   assign s_axi_rresp     = rresp_q;
   assign frame_sel       = fsel_q;
   assign table_clear     = clr_q;
   assign table_clear_idx = sel_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_set_only_on_edge;
      @(posedge aclk) disable iff (!aresetn)
      !req_rise |=> $stable(fsel_q);
   endproperty
   a_set_only_on_edge: assert property (p_set_only_on_edge) else $error("selection moved off edge");

   property p_advance_one;
      @(posedge aclk) disable iff (!aresetn)
      req_rise && seq_on_q && !rst_pend_q && cur_q < count_q
         |=> cur_q == next_set($past(cur_q), $past(count_q));
   endproperty
   a_advance_one: assert property (p_advance_one) else $error("set did not advance by one");

   property p_off_holds;
      @(posedge aclk) disable iff (!aresetn)
      req_rise && !seq_on_q && !rst_pend_q |=> cur_q == $past(cur_q) && fsel_q.table_idx == $past(sel_q);
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("off mode changed set");

   property p_uses_map;
      @(posedge aclk) disable iff (!aresetn)
      req_rise && seq_on_q && !rst_pend_q && cur_q < count_q
         |=> fsel_q.table_idx == $past(map_q[cur_q]);
   endproperty
   a_uses_map: assert property (p_uses_map) else $error("wrong table applied");

   property p_reset_zero;
      @(posedge aclk) disable iff (!aresetn)
      req_rise && seq_on_q && (rst_pend_q || cur_q >= count_q) |=> fsel_q.set_idx == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset did not give set zero");

   property p_count_range;
      @(posedge aclk) disable iff (!aresetn)
      count_q >= 5'h01 && count_q <= SET_W'(NUM_SETS) && cur_q < SET_W'(NUM_SETS);
   endproperty
   a_count_range: assert property (p_count_range) else $error("set index out of range");

   property p_set_in_count;
      @(posedge aclk) disable iff (!aresetn)
      req_rise && seq_on_q |=> fsel_q.set_idx < $past(count_q) && cur_q < $past(count_q);
   endproperty
   a_set_in_count: assert property (p_set_in_count) else $error("set past count");

   property p_ffc_gate;
      @(posedge aclk) disable iff (!aresetn)
      req_rise |=> fsel_q.ffc_on == $past(ffc_en_q);
   endproperty
   a_ffc_gate: assert property (p_ffc_gate) else $error("correction enable not followed");

   property p_table_range;
      @(posedge aclk) disable iff (!aresetn)
      sel_q < TBL_W'(NUM_TABLES) && fsel_q.table_idx < TBL_W'(NUM_TABLES);
   endproperty
   a_table_range: assert property (p_table_range) else $error("table index above nine");

endmodule : multi_ffc_sequencer
`default_nettype wire

// *** logic/seq_pkg.sv ***
// Package for the per-frame correction table sequencer
package seq_pkg;
   localparam int          NUM_SETS      = 30;
   localparam int          NUM_TABLES    = 10;
   localparam int          SET_W         = 5;
   localparam int          TBL_W         = 4;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_COUNT    = 8'h04;
   localparam logic [7:0]  ADDR_MAP      = 8'h08;
   localparam logic [7:0]  ADDR_CMD      = 8'h0C;
   localparam logic [7:0]  ADDR_STATUS   = 8'h10;
   localparam int          CTRL_SEQ_ON   = 0;
   localparam int          CTRL_FFC_EN   = 1;
   localparam int          CTRL_SEL_LSB  = 4;
   localparam int          MAP_SET_LSB   = 0;
   localparam int          MAP_TBL_LSB   = 8;
   localparam int          CMD_RESET     = 0;
   localparam int          CMD_CLEAR     = 1;
   localparam int          ST_SET_LSB    = 0;
   localparam int          ST_TBL_LSB    = 8;
   localparam int          ST_FFC_BIT    = 12;
   localparam logic [4:0]  COUNT_RESET   = 5'h01;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef struct packed {
      logic             ffc_on;
      logic [TBL_W-1:0] table_idx;
      logic [SET_W-1:0] set_idx;
   } frame_sel_t;
endpackage : seq_pkg

// *** tb/host_model.sv ***
// Host model that drives the register port as an AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released lines show the inverse of the last value; code 3 marks a hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      {aw, w, b} = 3'h7;
      r = 2'h3;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int n = 0; n < 200 && b; n++) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) begin
            b = 1'b0;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, rr;
      {ar, rr} = 2'h3;
      r = 2'h3;
      d = '0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int n = 0; n < 200 && rr; n++) begin
         @(posedge aclk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            rr = 1'b0;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            s_axi_rready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb/multi_ffc_sequencer_bench.sv ***
// Self-checking bench for the per-frame correction table sequencer
`timescale 1ns/1ps
`default_nettype none
module multi_ffc_sequencer_bench
   import seq_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0, frame_req = 1'b0;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, table_clear_idx;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        table_clear;
   frame_sel_t  frame_sel;
   int          miscompares = 0, num_checks = 0;
   always #2.5 aclk = ~aclk;
   multi_ffc_sequencer i_multi_ffc_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_req, .frame_sel,
      .table_clear, .table_clear_idx);
   host_model i_host_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      i_host_model.wr(a, d, r);
      chk("bresp", {30'h0, er}, {30'h0, r});
      if (r === 2'h3)
         results();
   endtask : wr_chk
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      i_host_model.rd(a, d, r);
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
      if (r === 2'h3)
         results();
   endtask : rd_chk
   // One frame request; selection lands one cycle after the edge is seen
   task automatic fr(input logic [4:0] es, input logic [3:0] et, input logic ef, input bit cs);
      frame_req <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      chk("table_idx", {28'h0, et}, {28'h0, frame_sel.table_idx});
      chk("ffc_on", {31'h0, ef}, {31'h0, frame_sel.ffc_on});
      if (cs)
         chk("set_idx", {27'h0, es}, {27'h0, frame_sel.set_idx});
      @(posedge aclk);
      frame_req <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : fr
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      rd_chk(ADDR_COUNT, 32'h0000_0001, RESP_OKAY);
      rd_chk(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
      rd_chk(8'h14, 32'h0000_0000, RESP_SLVERR);
      $display("test reset done");
   endtask : t_reset
   task automatic t_bad;
      wr_chk(ADDR_COUNT, 32'h0000_0000, RESP_SLVERR);
      wr_chk(ADDR_COUNT, 32'h0000_001F, RESP_SLVERR);
      wr_chk(ADDR_COUNT, 32'h0000_001E, RESP_OKAY);
      rd_chk(ADDR_COUNT, 32'h0000_001E, RESP_OKAY);
      wr_chk(ADDR_MAP, 32'h0000_001E, RESP_SLVERR);
      wr_chk(ADDR_MAP, 32'h0000_0A00, RESP_SLVERR);
      wr_chk(ADDR_CTRL, 32'h0000_00A3, RESP_SLVERR);
      rd_chk(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      wr_chk(ADDR_MAP, 32'h0000_011D, RESP_OKAY);
      $display("test refusals done");
   endtask : t_bad
   task automatic t_seq;
      wr_chk(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
      wr_chk(ADDR_COUNT, 32'h0000_0003, RESP_OKAY);
      for (int i = 0; i < 3; i++)
         wr_chk(ADDR_MAP, (9 - i) << 8 | i, RESP_OKAY);
      wr_chk(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
      for (int k = 0; k < 7; k++)
         fr(5'(k % 3), 4'(9 - k % 3), 1'b1, 1'b1);
      rd_chk(ADDR_STATUS, 32'h0000_1901, RESP_OKAY);
      wr_chk(ADDR_CMD, 32'h0000_0001, RESP_OKAY);
      fr(5'h0, 4'h9, 1'b1, 1'b1);
      fr(5'h1, 4'h8, 1'b1, 1'b1);
      $display("test sequence done");
   endtask : t_seq
   task automatic t_off;
      wr_chk(ADDR_CTRL, 32'h0000_0052, RESP_OKAY);
      fr(5'h0, 4'h5, 1'b1, 1'b0);
      fr(5'h0, 4'h5, 1'b1, 1'b0);
      rd_chk(ADDR_STATUS, 32'h0000_1502, RESP_OKAY);
      wr_chk(ADDR_CTRL, 32'h0000_0053, RESP_OKAY);
      fr(5'h2, 4'h7, 1'b1, 1'b1);
      wr_chk(ADDR_CTRL, 32'h0000_0051, RESP_OKAY);
      fr(5'h0, 4'h9, 1'b0, 1'b1);
      wr_chk(ADDR_CTRL, 32'h0000_0050, RESP_OKAY);
      wr_chk(ADDR_CMD, 32'h0000_0001, RESP_OKAY);
      fr(5'h1, 4'h5, 1'b0, 1'b1);
      rd_chk(ADDR_STATUS, 32'h0000_0500, RESP_OKAY);
      wr_chk(ADDR_CTRL, 32'h0000_0051, RESP_OKAY);
      fr(5'h0, 4'h9, 1'b0, 1'b1);
      fr(5'h1, 4'h8, 1'b0, 1'b1);
      wr_chk(ADDR_CTRL, 32'h0000_0050, RESP_OKAY);
      wr_chk(ADDR_COUNT, 32'h0000_0002, RESP_OKAY);
      wr_chk(ADDR_CTRL, 32'h0000_0051, RESP_OKAY);
      fr(5'h0, 4'h9, 1'b0, 1'b1);
      fr(5'h1, 4'h8, 1'b0, 1'b1);
      $display("test sequencer off done");
   endtask : t_off
   task automatic t_clear;
      int pulses;
      logic [3:0] idx;
      pulses = 0;
      idx = 4'h0;
      fork
         wr_chk(ADDR_CMD, 32'h0000_0002, RESP_OKAY);
         repeat (12) begin
            @(posedge aclk);
            if (table_clear === 1'b1) begin
               pulses++;
               idx = table_clear_idx;
            end
         end
      join
      chk("clear_pulses", 32'h0000_0001, pulses);
      chk("clear_idx", {28'h0, 4'h5}, {28'h0, idx});
      $display("test table clear done");
   endtask : t_clear
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      results();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_bad();
      t_seq();
      t_off();
      t_clear();
      results();
   end
endmodule : multi_ffc_sequencer_bench
`default_nettype wire
